/* File: include/sdc_params.svh */
// Constants of the seconds date counter and its register reader.
// Assumes a 100 MHz clock; included only by the package file, and the bench and checker write their figures out.
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

`define SDC_CLK_PERIOD_NS 10
`define SDC_MS_NS 1000000
`define SDC_CYC_PER_MS (`SDC_MS_NS / `SDC_CLK_PERIOD_NS)
`define SDC_SYNC_HOLD_H 2
`define SDC_SYNC_HOLD_S (`SDC_SYNC_HOLD_H * 3600)
`define SDC_REFRESH_MS 100
`define SDC_MS_WRAP 10'h03E7

`define SDC_REG_SECS_HI 16'h0B54
`define SDC_REG_SECS_LO 16'h0B55
`define SDC_REG_MSEC_Q 16'h0B56
`define SDC_ADDR_SECS_HI 16'h0B53
`define SDC_ADDR_MSEC_Q 16'h0B55
`define SDC_DS_FIRST_REG 16'h7D00
`define SDC_DS_LAST_REG 16'h7E55
`define SDC_DS_FIRST_ADDR 16'h7CFF
`define SDC_DS_LAST_ADDR 16'h7E54
`define SDC_DS_WORDS 342
`define SDC_DS_MIRROR_IDX 9'h153
`define SDC_DS_STATUS_IDX 9'h001
`define SDC_DS_FLOAT_IDX 9'h01C
`define SDC_DS_S16_IDX 9'h01E
`define SDC_DS_S32_IDX 9'h020
`define SDC_DS_NEUTRAL_IDX 9'h022
`define SDC_MAX_READ 8'h7D

`define SDC_MSEC_MASK 16'h03FF
`define SDC_BIT_EXT_SYNC 12
`define SDC_BIT_INT_SYNC 13
`define SDC_BIT_DATE_SET 14

`define SDC_NA_U16 32'h0000_FFFF
`define SDC_NA_S16 32'h0000_8000
`define SDC_NA_S32 32'h8000_0000
`define SDC_NA_F32 32'hFFC0_0000
`define SDC_NA_NEUTRAL 16'h8000

`define SDC_SECS_PER_DAY 32'h0001_5180
`define SDC_SECS_PER_HOUR 32'h0000_0E10
`define SDC_SECS_PER_MIN 32'h0000_003C
`define SDC_DAYS_YEAR 16'h016D
`define SDC_DAYS_LEAP 16'h016E
`define SDC_YEAR_NO_LEAP 8'h64

`endif

/* File: include/sdc_pkg.sv */
// Types shared by the date counter device and its register reader.
// Assumes sdc_params.svh is available on the include path.
`include "sdc_params.svh"

package sdc_pkg;

	typedef enum logic [3:0] {
		SDC_NA_T_U16 = 4'b0001,
		SDC_NA_T_S16 = 4'b0010,
		SDC_NA_T_S32 = 4'b0100,
		SDC_NA_T_F32 = 4'b1000
	} sdc_val_e;

	typedef enum logic [1:0] {
		SDC_DEV_IDLE = 2'b01,
		SDC_DEV_SEND = 2'b10
	} sdc_dev_state_e;

	typedef enum logic [6:0] {
		SDC_M_IDLE = 7'b000_0001,
		SDC_M_WAIT = 7'b000_0010,
		SDC_M_DAYS = 7'b000_0100,
		SDC_M_YEARS = 7'b000_1000,
		SDC_M_HOURS = 7'b001_0000,
		SDC_M_MINS = 7'b010_0000,
		SDC_M_DONE = 7'b100_0000
	} sdc_mst_state_e;

	// Out-of-order pattern by value type; a 16-bit type sits in the low half.
	function automatic logic [31:0] sdc_na_pattern(input sdc_val_e t);
		unique case (t)
			SDC_NA_T_U16: sdc_na_pattern = `SDC_NA_U16;
			SDC_NA_T_S16: sdc_na_pattern = `SDC_NA_S16;
			SDC_NA_T_S32: sdc_na_pattern = `SDC_NA_S32;
			default: sdc_na_pattern = `SDC_NA_F32;
		endcase
	endfunction : sdc_na_pattern

endpackage : sdc_pkg

/* File: include/sdc_bus_if.sv */
// Register read link between the supervising master and the date device.
// One request at a time; the master waits for the last word or the exception.
`timescale 1ns/1ps
`default_nettype none

interface sdc_bus_if;
	logic req_valid;
	logic [15:0] req_addr;
	logic [7:0] req_count;
	logic resp_valid;
	logic [15:0] resp_data;
	logic resp_last;
	logic resp_exc;

	modport device (
		input req_valid,
		input req_addr,
		input req_count,
		output resp_valid,
		output resp_data,
		output resp_last,
		output resp_exc
	);

	modport master (
		output req_valid,
		output req_addr,
		output req_count,
		input resp_valid,
		input resp_data,
		input resp_last,
		input resp_exc
	);
endinterface : sdc_bus_if

`default_nettype wire

/* File: core/sdc_date_device.sv */
// Seconds date counter with its read-only register answer logic.
// Assumes the bus master and all user inputs share clk; sys_rst is module power loss.
`timescale 1ns/1ps
`default_nettype none

module sdc_date_device
	import sdc_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = `SDC_CYC_PER_MS,
	parameter int unsigned SYNC_HOLD_S = `SDC_SYNC_HOLD_S,
	parameter int unsigned REFRESH_MS = `SDC_REFRESH_MS,
	parameter bit LEGACY_NA = 1'b0
)(
	input wire logic clk,
	input wire logic sys_rst,
	sdc_bus_if.device bus,
	input wire logic ext_sync,
	input wire logic [31:0] ext_sync_secs,
	input wire logic int_sync,
	input wire logic neutral_present,
	input wire logic meas_fault,
	input wire logic ds_wr_en,
	input wire logic [8:0] ds_wr_idx,
	input wire logic [15:0] ds_wr_data,
	output logic [31:0] secs_now,
	output logic date_set
);

	logic [31:0] ms_cyc;
	logic [9:0] msec;
	logic [31:0] sync_age;
	logic ext_ok;
	logic int_ok;
	logic [31:0] refresh_ms;
	logic [15:0] ds_mem [0:`SDC_DS_WORDS-1];
	logic [15:0] snap_hi;
	logic [15:0] snap_lo;
	logic [15:0] snap_q;
	logic [15:0] cur_addr;
	logic [7:0] remain;
	sdc_dev_state_e state;
	logic ms_tick;
	logic sec_tick;
	logic [15:0] quality;

	assign ms_tick = (ms_cyc == CYC_PER_MS - 1);
	assign sec_tick = ms_tick && (msec == `SDC_MS_WRAP);
	assign quality = {1'b0, date_set, int_ok, ext_ok, 2'b00, msec};

	// A sync restarts the millisecond phase so the loaded second is whole.
	always_ff @(posedge clk)
	begin
		if (sys_rst || ext_sync || ms_tick)
			ms_cyc <= 32'h0000_0000;
		else
			ms_cyc <= ms_cyc + 32'h0000_0001;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || ext_sync)
			msec <= 10'h000;
		else if (sec_tick)
			msec <= 10'h000;
		else if (ms_tick)
			msec <= msec + 10'h001;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			secs_now <= 32'h0000_0000;
		else if (ext_sync)
			secs_now <= ext_sync_secs;
		else if (sec_tick)
			secs_now <= secs_now + 32'h0000_0001;
	end

	// The age runs in seconds, so the two hour window needs no wide cycle counter.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ext_ok <= 1'b0;
			sync_age <= 32'h0000_0000;
		end
		else if (ext_sync)
		begin
			ext_ok <= 1'b1;
			sync_age <= 32'h0000_0000;
		end
		else if (sec_tick && ext_ok)
		begin
			if (sync_age == SYNC_HOLD_S - 1)
				ext_ok <= 1'b0;
			sync_age <= sync_age + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			int_ok <= 1'b0;
		else if (int_sync)
			int_ok <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			date_set <= 1'b0;
		else if (ext_sync)
			date_set <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || (ms_tick && refresh_ms == REFRESH_MS - 1))
			refresh_ms <= 32'h0000_0000;
		else if (ms_tick)
			refresh_ms <= refresh_ms + 32'h0000_0001;
	end

	// The date mirror is rewritten on each refresh and wins over a user write.
	always_ff @(posedge clk)
	begin
		if (ds_wr_en && ds_wr_idx < `SDC_DS_WORDS)
			ds_mem[ds_wr_idx] <= ds_wr_data;
		if (ms_tick && refresh_ms == REFRESH_MS - 1)
		begin
			ds_mem[`SDC_DS_MIRROR_IDX] <= secs_now[31:16];
			ds_mem[`SDC_DS_MIRROR_IDX + 9'h001] <= secs_now[15:0];
			ds_mem[`SDC_DS_MIRROR_IDX + 9'h002] <= quality;
		end
	end

	function automatic logic block_cut(input logic [16:0] f, input logic [16:0] l,
		input logic [16:0] lo, input logic [16:0] hi);
		block_cut = (f <= hi) && (l >= lo) && ((f > lo) || (l < hi));
	endfunction : block_cut

	function automatic logic read_ok(input logic [15:0] a, input logic [7:0] n);
		logic [16:0] f;
		logic [16:0] l;
		logic in_date;
		logic in_ds;
		f = {1'b0, a};
		l = {1'b0, a} + {9'h000, n} - 17'h0_0001;
		in_date = f >= {1'b0, `SDC_ADDR_SECS_HI} && l <= {1'b0, `SDC_ADDR_MSEC_Q};
		in_ds = f >= {1'b0, `SDC_DS_FIRST_ADDR} && l <= {1'b0, `SDC_DS_LAST_ADDR};
		read_ok = n != 8'h00 && n <= `SDC_MAX_READ && (in_date || in_ds)
			&& !block_cut(f, l, {1'b0, `SDC_ADDR_SECS_HI}, {1'b0, `SDC_ADDR_SECS_HI} + 17'h0_0001)
			&& !block_cut(f, l, {1'b0, `SDC_DS_FIRST_ADDR} + {8'h00, `SDC_DS_FLOAT_IDX},
				{1'b0, `SDC_DS_FIRST_ADDR} + {8'h00, `SDC_DS_FLOAT_IDX} + 17'h0_0001)
			&& !block_cut(f, l, {1'b0, `SDC_DS_FIRST_ADDR} + {8'h00, `SDC_DS_S32_IDX},
				{1'b0, `SDC_DS_FIRST_ADDR} + {8'h00, `SDC_DS_S32_IDX} + 17'h0_0001)
			&& !block_cut(f, l, {1'b0, `SDC_DS_FIRST_ADDR} + {8'h00, `SDC_DS_MIRROR_IDX},
				{1'b0, `SDC_DS_FIRST_ADDR} + {8'h00, `SDC_DS_MIRROR_IDX} + 17'h0_0001);
	endfunction : read_ok

	// Only a handful of dataset words carry a typed out-of-order answer.
	function automatic logic [15:0] ds_word(input logic [8:0] i);
		logic [31:0] p;
		p = 32'h0000_0000;
		ds_word = ds_mem[i];
		if (i == `SDC_DS_NEUTRAL_IDX && !neutral_present)
			ds_word = `SDC_NA_NEUTRAL;
		else if (meas_fault)
		begin
			if (i == `SDC_DS_STATUS_IDX)
			begin
				p = sdc_na_pattern(LEGACY_NA ? SDC_NA_T_S16 : SDC_NA_T_U16);
				ds_word = p[15:0];
			end
			else if (i == `SDC_DS_S16_IDX)
			begin
				p = sdc_na_pattern(SDC_NA_T_S16);
				ds_word = p[15:0];
			end
			else if (i == `SDC_DS_S32_IDX || i == `SDC_DS_S32_IDX + 9'h001)
			begin
				p = sdc_na_pattern(SDC_NA_T_S32);
				ds_word = i[0] ? p[15:0] : p[31:16];
			end
			else if (i == `SDC_DS_FLOAT_IDX || i == `SDC_DS_FLOAT_IDX + 9'h001)
			begin
				p = sdc_na_pattern(SDC_NA_T_F32);
				ds_word = i[0] ? p[15:0] : p[31:16];
			end
		end
	endfunction : ds_word

	function automatic logic [15:0] word_at(input logic [15:0] a);
		logic [15:0] di;
		di = a - `SDC_DS_FIRST_ADDR;
		if (a == `SDC_ADDR_SECS_HI)
			word_at = snap_hi;
		else if (a == `SDC_ADDR_SECS_HI + 16'h0001)
			word_at = snap_lo;
		else if (a == `SDC_ADDR_MSEC_Q)
			word_at = snap_q;
		else
			word_at = ds_word(di[8:0]);
	endfunction : word_at

	// The date words are frozen at the request so high, low and msec agree.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= SDC_DEV_IDLE;
			cur_addr <= 16'h0000;
			remain <= 8'h00;
			snap_hi <= 16'h0000;
			snap_lo <= 16'h0000;
			snap_q <= 16'h0000;
			bus.resp_valid <= 1'b0;
			bus.resp_data <= 16'h0000;
			bus.resp_last <= 1'b0;
			bus.resp_exc <= 1'b0;
		end
		else
		begin
			bus.resp_valid <= 1'b0;
			bus.resp_last <= 1'b0;
			bus.resp_exc <= 1'b0;
			unique case (state)
				SDC_DEV_IDLE:
				begin
					if (bus.req_valid)
					begin
						if (read_ok(bus.req_addr, bus.req_count))
						begin
							cur_addr <= bus.req_addr;
							remain <= bus.req_count;
							snap_hi <= secs_now[31:16];
							snap_lo <= secs_now[15:0];
							snap_q <= quality;
							state <= SDC_DEV_SEND;
						end
						else
						begin
							bus.resp_valid <= 1'b1;
							bus.resp_last <= 1'b1;
							bus.resp_exc <= 1'b1;
						end
					end
				end
				SDC_DEV_SEND:
				begin
					bus.resp_valid <= 1'b1;
					bus.resp_data <= word_at(cur_addr);
					bus.resp_last <= (remain == 8'h01);
					cur_addr <= cur_addr + 16'h0001;
					remain <= remain - 8'h01;
					if (remain == 8'h01)
						state <= SDC_DEV_IDLE;
				end
			endcase
		end
	end

endmodule : sdc_date_device

`default_nettype wire

/* File: core/sdc_date_master.sv */
// Supervising master that reads registers and turns the date into calendar fields.
// Assumes one request outstanding at a time on the shared link and clock.
`timescale 1ns/1ps
`default_nettype none

module sdc_date_master
	import sdc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	sdc_bus_if.master bus,
	input wire logic date_req,
	input wire logic rd_req,
	input wire logic [15:0] rd_regnum,
	input wire logic [7:0] rd_count,
	output logic busy,
	output logic rd_valid,
	output logic [15:0] rd_data,
	output logic rd_last,
	output logic rd_err,
	output logic date_valid,
	output logic [7:0] year_ofs,
	output logic [8:0] day_of_year,
	output logic [4:0] hour,
	output logic [5:0] minute,
	output logic [5:0] second,
	output logic [9:0] msec,
	output logic [2:0] quality
);

	sdc_mst_state_e state;
	logic is_date;
	logic [1:0] word_no;
	logic [31:0] rem_s;
	logic [15:0] days;
	logic [15:0] year_len;

	assign year_len = (year_ofs[1:0] == 2'b00 && year_ofs != `SDC_YEAR_NO_LEAP)
		? `SDC_DAYS_LEAP : `SDC_DAYS_YEAR;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= SDC_M_IDLE;
			is_date <= 1'b0;
			word_no <= 2'b00;
			rem_s <= 32'h0000_0000;
			days <= 16'h0000;
			busy <= 1'b0;
			bus.req_valid <= 1'b0;
			bus.req_addr <= 16'h0000;
			bus.req_count <= 8'h00;
			rd_valid <= 1'b0;
			rd_data <= 16'h0000;
			rd_last <= 1'b0;
			rd_err <= 1'b0;
			date_valid <= 1'b0;
			year_ofs <= 8'h00;
			day_of_year <= 9'h000;
			hour <= 5'h00;
			minute <= 6'h00;
			second <= 6'h00;
			msec <= 10'h000;
			quality <= 3'b000;
		end
		else
		begin
			bus.req_valid <= 1'b0;
			rd_valid <= 1'b0;
			rd_last <= 1'b0;
			rd_err <= 1'b0;
			date_valid <= 1'b0;
			unique case (state)
				SDC_M_IDLE:
				begin
					word_no <= 2'b00;
					if (date_req)
					begin
						// The date comes from the dataset mirror, refreshed every REFRESH_MS ms, at the same answer speed as the device registers.
						bus.req_valid <= 1'b1;
						bus.req_addr <= `SDC_DS_FIRST_ADDR + {7'h00, `SDC_DS_MIRROR_IDX};
						bus.req_count <= 8'h03;
						is_date <= 1'b1;
						busy <= 1'b1;
						state <= SDC_M_WAIT;
					end
					else if (rd_req)
					begin
						if (rd_count == 8'h00 || rd_count > `SDC_MAX_READ)
							rd_err <= 1'b1;
						else
						begin
							bus.req_valid <= 1'b1;
							bus.req_addr <= rd_regnum - 16'h0001;
							bus.req_count <= rd_count;
							is_date <= 1'b0;
							busy <= 1'b1;
							state <= SDC_M_WAIT;
						end
					end
				end
				SDC_M_WAIT:
				begin
					if (bus.resp_valid)
					begin
						if (bus.resp_exc)
						begin
							rd_err <= 1'b1;
							busy <= 1'b0;
							state <= SDC_M_IDLE;
						end
						else if (is_date)
						begin
							word_no <= word_no + 2'b01;
							if (word_no == 2'b00)
								rem_s[31:16] <= bus.resp_data;
							else if (word_no == 2'b01)
								rem_s[15:0] <= bus.resp_data;
							else
							begin
								msec <= 10'(bus.resp_data & `SDC_MSEC_MASK);
								quality <= bus.resp_data[`SDC_BIT_DATE_SET:`SDC_BIT_EXT_SYNC];
								days <= 16'h0000;
								state <= SDC_M_DAYS;
							end
						end
						else
						begin
							rd_valid <= 1'b1;
							rd_data <= bus.resp_data;
							rd_last <= bus.resp_last;
							if (bus.resp_last)
							begin
								busy <= 1'b0;
								state <= SDC_M_IDLE;
							end
						end
					end
				end
				// Repeated subtraction trades about fifty thousand cycles for no divider.
				SDC_M_DAYS:
				begin
					if (rem_s >= `SDC_SECS_PER_DAY)
					begin
						rem_s <= rem_s - `SDC_SECS_PER_DAY;
						days <= days + 16'h0001;
					end
					else
					begin
						year_ofs <= 8'h00;
						hour <= 5'h00;
						state <= SDC_M_YEARS;
					end
				end
				SDC_M_YEARS:
				begin
					if (days >= year_len)
					begin
						days <= days - year_len;
						year_ofs <= year_ofs + 8'h01;
					end
					else
					begin
						day_of_year <= days[8:0] + 9'h001;
						state <= SDC_M_HOURS;
					end
				end
				SDC_M_HOURS:
				begin
					if (rem_s >= `SDC_SECS_PER_HOUR)
					begin
						rem_s <= rem_s - `SDC_SECS_PER_HOUR;
						hour <= hour + 5'h01;
					end
					else
					begin
						minute <= 6'h00;
						state <= SDC_M_MINS;
					end
				end
				SDC_M_MINS:
				begin
					if (rem_s >= `SDC_SECS_PER_MIN)
					begin
						rem_s <= rem_s - `SDC_SECS_PER_MIN;
						minute <= minute + 6'h01;
					end
					else
					begin
						second <= rem_s[5:0];
						state <= SDC_M_DONE;
					end
				end
				SDC_M_DONE:
				begin
					date_valid <= 1'b1;
					busy <= 1'b0;
					state <= SDC_M_IDLE;
				end
			endcase
		end
	end

endmodule : sdc_date_master

`default_nettype wire

/* File: bench/sdc_date_checker.sv */
// Assertions on the register link between the date master and the date device.
// Assumes one clock domain; the link signals come in as plain inputs.
`timescale 1ns/1ps
`default_nettype none

module sdc_date_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_count,
	input wire logic resp_valid,
	input wire logic [15:0] resp_data,
	input wire logic resp_last,
	input wire logic resp_exc
);
	logic dev_busy;
	logic [7:0] n_words;
	logic [7:0] want_words;
	wire logic take = req_valid && !dev_busy;
	wire logic in_date = req_addr >= 16'h0B53 && req_addr <= 16'h0B55;
	wire logic in_ds = req_addr >= 16'h7CFF && req_addr <= 16'h7E54;

	default clocking dck @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// The device drops requests while it answers, so only a request seen idle counts.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			dev_busy <= 1'b0;
		else if (take)
			dev_busy <= 1'b1;
		else if (resp_valid && resp_last)
			dev_busy <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || take)
			n_words <= 8'h00;
		else if (resp_valid)
			n_words <= n_words + 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (take)
			want_words <= req_count;
	end

	a_exc_marks_last: assert property (resp_exc |-> resp_valid && resp_last)
		else $error("exception answer without valid and last");
	a_undoc_addr_exc: assert property (take && !in_date && !in_ds |=> resp_valid && resp_exc)
		else $error("undocumented address answered with data");
	a_split_pair_exc: assert property (take && (req_addr == 16'h0B54 ||
		(req_addr == 16'h0B53 && req_count == 8'h01)) |=> resp_exc)
		else $error("partial seconds read not refused");
	a_date_words: assert property (take && req_addr == 16'h0B53 && req_count == 8'h03 |=>
		!resp_valid ##1 (resp_valid && !resp_exc && !resp_last) ##1
		(resp_valid && !resp_last) ##1 (resp_valid && resp_last))
		else $error("date words not answered in order");
	a_quality_spare: assert property (take && req_addr == 16'h0B55 && req_count == 8'h01 |->
		##2 resp_valid && !resp_exc && !resp_data[15] && resp_data[11:10] == 2'h0 &&
		resp_data[9:0] <= 10'h3E7)
		else $error("milliseconds word has bad spare bits or range");
	a_ds_past_end_exc: assert property (take && req_addr == 16'h7E54 && req_count == 8'h02 |=>
		resp_exc)
		else $error("read past the dataset not refused");
	a_ds_full_read: assert property (take && req_addr == 16'h7CFF && req_count == 8'h7D |->
		##2 resp_valid && !resp_exc)
		else $error("full dataset block refused");
	a_block_read_whole: assert property (resp_valid && resp_last && !resp_exc |->
		n_words == want_words - 8'h01)
		else $error("answer word count differs from request");

	c_exception: cover property (resp_exc);
	c_date_read: cover property (take && req_addr == 16'h0B53 && req_count == 8'h03);
	c_ds_read: cover property (take && in_ds);
endmodule : sdc_date_checker

`default_nettype wire

/* File: bench/tb_seconds_date_counter.sv */
// Self-checking bench: date device and date master joined by their link.
// Assumes shortened counts, so one second is 2000 clocks and sync holds 2 s.
`timescale 1ns/1ps
`default_nettype none

module tb_seconds_date_counter;
	localparam int unsigned CPM = 2;
	localparam logic [31:0] SECS = 400 * 86400 + 3 * 3600 + 25 * 60 + 7;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ext_sync = 1'b0;
	logic [31:0] ext_sync_secs = 32'h0;
	logic int_sync = 1'b0;
	logic neutral_present = 1'b1;
	logic meas_fault = 1'b0;
	logic ds_wr_en = 1'b0;
	logic [8:0] ds_wr_idx = 9'h0;
	logic [15:0] ds_wr_data = 16'h0;
	logic date_req = 1'b0;
	logic rd_req = 1'b0;
	logic [15:0] rd_regnum = 16'h0;
	logic [7:0] rd_count = 8'h0;
	logic busy, rd_valid, rd_last, rd_err, date_valid, date_set, got_err;
	logic [15:0] rd_data;
	logic [31:0] secs_now;
	logic [7:0] year_ofs;
	logic [8:0] day_of_year;
	logic [4:0] hour;
	logic [5:0] minute, second;
	logic [9:0] msec;
	logic [2:0] quality;
	logic [31:0] words [0:127];
	logic [31:0] ds_exp [0:6] = '{32'hFFC0, 32'h0, 32'h8000, 32'h1234, 32'h8000, 32'h0, 32'h8000};
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	sdc_bus_if link ();

	always #5 clk = ~clk;

	sdc_date_device #(.CYC_PER_MS(CPM), .SYNC_HOLD_S(2), .REFRESH_MS(2), .LEGACY_NA(1'b0))
		u_sdc_date_device (.clk(clk), .sys_rst(sys_rst), .bus(link.device),
		.ext_sync(ext_sync), .ext_sync_secs(ext_sync_secs), .int_sync(int_sync),
		.neutral_present(neutral_present), .meas_fault(meas_fault), .ds_wr_en(ds_wr_en),
		.ds_wr_idx(ds_wr_idx), .ds_wr_data(ds_wr_data), .secs_now(secs_now),
		.date_set(date_set));
	sdc_date_master u_sdc_date_master (.clk(clk), .sys_rst(sys_rst), .bus(link.master),
		.date_req(date_req), .rd_req(rd_req), .rd_regnum(rd_regnum), .rd_count(rd_count),
		.busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last),
		.rd_err(rd_err), .date_valid(date_valid), .year_ofs(year_ofs),
		.day_of_year(day_of_year), .hour(hour), .minute(minute), .second(second),
		.msec(msec), .quality(quality));
	sdc_date_checker u_sdc_date_checker (.clk(clk), .sys_rst(sys_rst),
		.req_valid(link.req_valid), .req_addr(link.req_addr), .req_count(link.req_count),
		.resp_valid(link.resp_valid), .resp_data(link.resp_data),
		.resp_last(link.resp_last), .resp_exc(link.resp_exc));

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// The whole run needs about 5000 clocks; a hang stops well past that.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			finish_test();
		end
	end

	task automatic power_loss();
		sys_rst = 1'b1;
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
	endtask : power_loss

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse

	task automatic ds_wr(input logic [8:0] idx, input logic [15:0] d);
		@(negedge clk);
		ds_wr_idx = idx;
		ds_wr_data = d;
		ds_wr_en = 1'b1;
		@(negedge clk);
		ds_wr_en = 1'b0;
	endtask : ds_wr

	// Reads by register number through the master; the last word or a refusal ends it.
	task automatic rd(input logic [15:0] rn, input logic [7:0] cnt, input logic xerr);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(negedge clk);
		rd_regnum = rn;
		rd_count = cnt;
		rd_req = 1'b1;
		for (int t = 0; t < 400 && !done; t++)
		begin
			@(negedge clk);
			rd_req = 1'b0;
			if (rd_valid === 1'b1)
			begin
				words[n] = {16'h0, rd_data};
				n++;
			end
			done = rd_last === 1'b1 || rd_err === 1'b1;
		end
		got_err = rd_err === 1'b1;
		while (busy !== 1'b0)
			@(negedge clk);
		chk("error flag", 32'(xerr), 32'(got_err));
		chk("answer end", 32'h1, 32'(done));
		if (!xerr)
			chk("word count", 32'(cnt), 32'(n));
	endtask : rd

	initial
	begin
		power_loss();
		rd(16'h0B56, 8'h01, 1'b0);
		chk("flags", 32'h0, 32'(words[0][14:12]));
		chk("spare", 32'h0, 32'({words[0][15], words[0][11:10]}));
		pulse(int_sync);
		rd(16'h0B56, 8'h01, 1'b0);
		chk("flags", 32'h2, 32'(words[0][14:12]));
		ext_sync_secs = SECS;
		pulse(ext_sync);
		chk("date_set", 32'h1, 32'(date_set));
		chk("secs_now", SECS, secs_now);
		rd(16'h0B54, 8'h03, 1'b0);
		chk("secs", SECS, {words[0][15:0], words[1][15:0]});
		chk("flags", 32'h7, 32'(words[2][14:12]));
		chk("msec", 32'h0, 32'(words[2][9:0] > 10'h3E7));
		@(negedge clk);
		date_req = 1'b1;
		@(negedge clk);
		date_req = 1'b0;
		for (int t = 0; t < 5000 && date_valid !== 1'b1; t++)
			@(negedge clk);
		chk("year", 32'h1, 32'(year_ofs));
		chk("day", 32'(400 - 366 + 1), 32'(day_of_year));
		chk("hms", 32'({5'h03, 6'h19, 6'h07}), 32'({hour, minute, second}));
		chk("quality", 32'h7, 32'(quality));
		chk("msec field", 32'h0, 32'(msec > 10'h3E7));
		// Two whole seconds on, the sync flag has lapsed and the count moved by two.
		repeat (2 * CPM * 1000) @(negedge clk);
		rd(16'h0B54, 8'h03, 1'b0);
		chk("secs", SECS + 32'h2, {words[0][15:0], words[1][15:0]});
		chk("flags", 32'h6, 32'(words[2][14:12]));
		rd(16'h0B54, 8'h00, 1'b1);
		rd(16'h0B54, 8'h7E, 1'b1);
		rd(16'h0064, 8'h01, 1'b1);
		rd(16'h0B55, 8'h02, 1'b1);
		rd(16'h0B54, 8'h01, 1'b1);
		rd(16'h7E55, 8'h02, 1'b1);
		rd(16'h7E55, 8'h01, 1'b0);
		rd(16'h7D00, 8'h7D, 1'b0);
		meas_fault = 1'b1;
		neutral_present = 1'b0;
		ds_wr(9'h01F, 16'h1234);
		rd(16'h7D01, 8'h01, 1'b0);
		chk("u16 na", 32'hFFFF, words[0]);
		rd(16'h7D1C, 8'h07, 1'b0);
		for (int i = 0; i < 7; i++)
			chk("typed na", ds_exp[i], words[i]);
		rd(16'h7D1C, 8'h01, 1'b1);
		power_loss();
		rd(16'h0B54, 8'h03, 1'b0);
		chk("secs", 32'h0, {words[0][15:0], words[1][15:0]});
		chk("flags", 32'h0, 32'(words[2][14:12]));
		finish_test();
	end
endmodule : tb_seconds_date_counter

`default_nettype wire
